// ### pkg/probe_capture_pkg.sv
// Shared constants and types of the probe capture serial readout.
// Assumes a single clock domain and a synchronous active-low reset.
package probe_capture_pkg;

    // ****************************************************************
    // Widths and depths
    // ****************************************************************
    localparam int unsigned DATA_W     = 24;
    localparam int unsigned FIFO_DEPTH = 32;

    // ****************************************************************
    // Channel numbers and reset values
    // ****************************************************************
    localparam logic [1:0] CHAN_ZERO  = 2'h0;
    localparam logic [1:0] CHAN_ONE   = 2'h1;
    localparam logic [1:0] CHAN_TWO   = 2'h2;
    localparam logic       ENABLE_RST = 1'h0;
    localparam logic [DATA_W-1:0] CAPTURE_RST = 24'h00_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [1:0]        chan;
        logic              nErr;
        logic              nWarn;
        logic [DATA_W-1:0] data;
    } chan_word_s;

    localparam int unsigned WORD_W = $bits(chan_word_s);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CH0  = 4'b0010,
        ST_CH1  = 4'b0100,
        ST_CH2  = 4'b1000
    } frame_state_e;

endpackage

// ### core/probe_capture_serial_readout.sv
// Probe capture bookkeeping and sensor-data frame builder, with its FIFO.
// Assumes counter value, commands and config come from logic on clock;
// only the probe trigger pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Word FIFO with registered head
// ********************************************************************
module word_fifo #(
    parameter int unsigned WIDTH = 28,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             loadHead;

    assign inReady  = (count_q != CW'(DEPTH));
    assign push     = inValid && inReady;
    assign loadHead = (count_q != '0) && (!outValid || outReady);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wrPtr_q  <= '0;
            rdPtr_q  <= '0;
            count_q  <= '0;
            outValid <= 1'b0;
            outData  <= '0;
        end else begin
            wrPtr_q <= push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
            rdPtr_q <= loadHead ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
            count_q <= CW'(count_q + CW'(push) - CW'(loadHead));
            if (loadHead) begin
                outData  <= mem[rdPtr_q];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end
endmodule // word_fifo

// ********************************************************************
// Top: capture registers and frame builder
// ********************************************************************
module probe_capture_serial_readout (
    input  wire logic                                clock,
    input  wire logic                                nrst,
    input  wire logic                                probeTriggerPin,
    input  wire logic                                probeCaptureCmd,
    input  wire logic [probe_capture_pkg::DATA_W-1:0] counterZero,
    input  wire logic [probe_capture_pkg::DATA_W-1:0] updValue,
    input  wire logic                                updValidN,
    input  wire logic                                abErrN,
    input  wire logic                                counterErrN,
    input  wire logic                                counterWarnN,
    input  wire logic                                channel1Enable,
    input  wire logic                                channel2Enable,
    input  wire logic                                channel1ContentSelect,
    input  wire logic                                channel2ContentSelect,
    input  wire logic                                statusRead,
    input  wire logic                                frameReq,
    output logic                                     frameBusy,
    output logic                                     captureValid,
    output logic                                     outValid,
    input  wire logic                                outReady,
    output probe_capture_pkg::chan_word_s            outWord
);
    localparam int unsigned DW = probe_capture_pkg::DATA_W;

    function automatic logic [DW-1:0] to_gray(input logic [DW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    logic                              pinMeta_q;
    logic                              pinSync_q;
    logic                              pinPrev_q;
    logic [2:0]                        pinArm_q;
    logic                              en1_q;
    logic                              en2_q;
    logic [DW-1:0]                     firstCap_q;
    logic [DW-1:0]                     secondCap_q;
    logic                              fromPin_q;
    probe_capture_pkg::frame_state_e   state_q;
    probe_capture_pkg::frame_state_e   state_d;
    probe_capture_pkg::chan_word_s     word;
    logic                              fifoReady;
    logic                              pushWord;
    logic                              pinEdge;
    logic                              capture;
    logic                              ch1ReadsCapture;
    logic                              clearValid;

    // ****************************************************************
    // Trigger sources and capture
    // ****************************************************************
    // Both pin edges capture; ignored until the synchroniser has
    // refilled after reset, so an idle-high pin fakes no edge
    assign pinEdge = pinArm_q[2] && (pinSync_q ^ pinPrev_q);
    assign capture = pinEdge || probeCaptureCmd;

    assign ch1ReadsCapture = pushWord && (state_q == probe_capture_pkg::ST_CH1)
                             && channel1ContentSelect;
    assign clearValid = statusRead || ch1ReadsCapture;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pinMeta_q    <= 1'b0;
            pinSync_q    <= 1'b0;
            pinPrev_q    <= 1'b0;
            pinArm_q     <= 3'h0;
            en1_q        <= probe_capture_pkg::ENABLE_RST;
            en2_q        <= probe_capture_pkg::ENABLE_RST;
            firstCap_q   <= probe_capture_pkg::CAPTURE_RST;
            secondCap_q  <= probe_capture_pkg::CAPTURE_RST;
            fromPin_q    <= 1'b0;
            captureValid <= 1'b0;
        end else begin
            pinMeta_q <= probeTriggerPin;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
            pinArm_q  <= {pinArm_q[1:0], 1'b1};
            en1_q     <= channel1Enable;
            en2_q     <= channel2Enable;
            if (capture) begin
                firstCap_q  <= counterZero;
                secondCap_q <= firstCap_q;
                fromPin_q   <= pinEdge;
            end
            // A capture in the clearing cycle wins
            captureValid <= capture || (captureValid && !clearValid);
        end
    end

    // ****************************************************************
    // Frame sequencing
    // ****************************************************************
    assign pushWord = !state_q[0] && fifoReady;

    always_comb begin
        state_d = state_q;
        case (state_q)
            probe_capture_pkg::ST_IDLE: begin
                if (frameReq) state_d = probe_capture_pkg::ST_CH0;
            end
            probe_capture_pkg::ST_CH0: begin
                if (pushWord) begin
                    state_d = en1_q ? probe_capture_pkg::ST_CH1
                            : en2_q ? probe_capture_pkg::ST_CH2
                            : probe_capture_pkg::ST_IDLE;
                end
            end
            probe_capture_pkg::ST_CH1: begin
                if (pushWord) begin
                    state_d = en2_q ? probe_capture_pkg::ST_CH2
                            : probe_capture_pkg::ST_IDLE;
                end
            end
            probe_capture_pkg::ST_CH2: begin
                if (pushWord) state_d = probe_capture_pkg::ST_IDLE;
            end
            default: state_d = probe_capture_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q   <= probe_capture_pkg::ST_IDLE;
            frameBusy <= 1'b0;
        end else begin
            state_q   <= state_d;
            frameBusy <= (state_d != probe_capture_pkg::ST_IDLE);
        end
    end

    // ****************************************************************
    // Channel word contents
    // ****************************************************************
    always_comb begin
        word.chan  = probe_capture_pkg::CHAN_ZERO;
        // Counter sampled as-is; flicker near a carry can glitch
        word.data  = counterZero;
        word.nErr  = counterErrN;
        word.nWarn = counterWarnN;
        case (state_q)
            probe_capture_pkg::ST_CH1: begin
                word.chan = probe_capture_pkg::CHAN_ONE;
                word.nErr = abErrN;
                if (channel1ContentSelect) begin
                    word.data  = firstCap_q;
                    // Captures without a pin edge in their cycle never report valid here
                    word.nWarn = !(captureValid && fromPin_q);
                end else begin
                    word.data  = updValue;
                    word.nWarn = updValidN;
                end
            end
            probe_capture_pkg::ST_CH2: begin
                word.chan  = probe_capture_pkg::CHAN_TWO;
                word.nErr  = abErrN;
                word.data  = to_gray(channel2ContentSelect ?
                                     secondCap_q : firstCap_q);
                word.nWarn = !captureValid;
            end
            default: word.chan = probe_capture_pkg::CHAN_ZERO;
        endcase
    end

    word_fifo #(
        .WIDTH (probe_capture_pkg::WORD_W),
        .DEPTH (probe_capture_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .nrst     (nrst),
        .inValid  (!state_q[0]),
        .inReady  (fifoReady),
        .inData   (word),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outWord)
    );
endmodule // probe_capture_serial_readout

`default_nettype wire

// ### testbench/probe_capture_checker.sv
// Assertions on the ports of the probe capture readout.
// Bound to the top module; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module probe_capture_checker (
    input wire logic                         clock,
    input wire logic                         nrst,
    input wire logic                         probeTriggerPin,
    input wire logic                         probeCaptureCmd,
    input wire logic                         statusRead,
    input wire logic                         channel2Enable,
    input wire logic                         frameReq,
    input wire logic                         frameBusy,
    input wire logic                         captureValid,
    input wire logic                         outValid,
    input wire logic                         outReady,
    input wire probe_capture_pkg::chan_word_s outWord
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence sHeld;
        outValid && !outReady;
    endsequence
    sequence sCh2Off;
        !channel2Enable [*8];
    endsequence
    AST_HOLD: assert property (sHeld |=> outValid && $stable(outWord))
        else $error("Head word changed while stalled");
    AST_CH2_OFF: assert property (sCh2Off ##0 outValid |->
        outWord.chan != probe_capture_pkg::CHAN_TWO)
        else $error("Disabled channel two in stream");
    AST_RST: assert property ($rose(nrst) |->
        !outValid && !captureValid && !frameBusy)
        else $error("Outputs not cleared by reset");
    AST_SET: assert property (probeCaptureCmd |-> ##[1:2] captureValid)
        else $error("Capture did not set valid");
    // A pin change that reaches the edge detector in the clearing cycle
    // captures, and capture beats clear
    AST_CLR: assert property (statusRead && !probeCaptureCmd &&
        $past(probeTriggerPin, 2) == $past(probeTriggerPin, 3)
        |=> !captureValid)
        else $error("Status read did not clear valid");
    AST_KEEP: assert property (captureValid && !statusRead &&
        !frameBusy |=> captureValid)
        else $error("Valid dropped without a clearing read");
    AST_START: assert property (frameReq && !frameBusy |=> frameBusy)
        else $error("Frame request not taken");
    AST_END: assert property ($rose(frameBusy) |-> ##[1:1000] !frameBusy)
        else $error("Frame never finished");
endmodule // probe_capture_checker
bind probe_capture_serial_readout probe_capture_checker u_chk (.clock(clock),
    .nrst(nrst), .probeTriggerPin(probeTriggerPin),
    .probeCaptureCmd(probeCaptureCmd), .statusRead(statusRead),
    .channel2Enable(channel2Enable), .frameReq(frameReq),
    .frameBusy(frameBusy), .captureValid(captureValid),
    .outValid(outValid), .outReady(outReady), .outWord(outWord));
`default_nettype wire

// ### testbench/word_sink.sv
// Consumer model for the output word stream; keeps what it accepts.
// Assumes the bench drives stall and slow between falling edges.
`timescale 1ns/1ps
`default_nettype none
module word_sink (
    input wire logic                         clock,
    input wire logic                         stall,
    input wire logic                         slow,
    input wire logic                         outValid,
    input wire probe_capture_pkg::chan_word_s outWord,
    output logic                             outReady
);
    probe_capture_pkg::chan_word_s got[$];
    logic                          phase = 1'h0;
    initial outReady = 1'h0;
    // Slow mode accepts on every other cycle
    always @(negedge clock) begin
        phase <= !phase;
        outReady <= !stall && (!slow || phase);
    end
    always @(posedge clock) begin
        if (outValid === 1'h1 && outReady === 1'h1)
            got.push_back(outWord);
    end
endmodule // word_sink
`default_nettype wire

// ### testbench/test_probe_capture_serial_readout.sv
// Self-checking bench: captures, channel frames and FIFO back-pressure.
// Assumes the sink model at the stream side.
`timescale 1ns/1ps
`default_nettype none
module test_probe_capture_serial_readout;
    logic clock = 1'h0, nrst = 1'h0, probeTriggerPin = 1'h0;
    logic probeCaptureCmd = 1'h0, statusRead = 1'h0, frameReq = 1'h0;
    logic [23:0] counterZero = 24'h12_3456, updValue = 24'h00_5A5A;
    logic updValidN = 1'h1, abErrN = 1'h1, counterErrN = 1'h1;
    logic counterWarnN = 1'h0, channel1Enable = 1'h0, channel2Enable = 1'h0;
    logic channel1ContentSelect = 1'h0, channel2ContentSelect = 1'h0;
    logic stall = 1'h0, slow = 1'h0, frameBusy, captureValid, outValid;
    logic outReady;
    probe_capture_pkg::chan_word_s outWord;
    int   errors = 0, n_compared = 0, cyc = 0, i;
    probe_capture_serial_readout DUT (.clock, .nrst, .probeTriggerPin,
        .probeCaptureCmd, .counterZero, .updValue, .updValidN, .abErrN,
        .counterErrN, .counterWarnN, .channel1Enable, .channel2Enable,
        .channel1ContentSelect, .channel2ContentSelect, .statusRead,
        .frameReq, .frameBusy, .captureValid, .outValid, .outReady, .outWord);
    word_sink sink (.clock, .stall, .slow, .outValid, .outWord, .outReady);
    always #25 clock = !clock;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [23:0] gray(logic [23:0] b);
        return b ^ (b >> 1);
    endfunction
    task automatic frame();
        int k;
        @(negedge clock);
        frameReq = 1'h1;
        @(negedge clock);
        frameReq = 1'h0;
        for (k = 0; k < 50 && frameBusy !== 1'h0; k++) @(negedge clock);
    endtask
    task automatic take(logic [1:0] ch, logic e, logic w, logic [23:0] d);
        int k;
        for (k = 0; k < 100 && sink.got.size() == 0; k++) @(negedge clock);
        if (sink.got.size() == 0)
            check(32'h0000_0000, 32'h0000_0001);
        else
            check(sink.got.pop_front(), {ch, e, w, d});
    endtask
    task automatic cfg(logic e1, logic e2, logic s1, logic s2);
        @(negedge clock);
        channel1Enable = e1;
        channel2Enable = e2;
        channel1ContentSelect = s1;
        channel2ContentSelect = s2;
        repeat (2) @(negedge clock);
    endtask
    task automatic capture(logic [23:0] v);
        counterZero = v;
        @(negedge clock);
        probeCaptureCmd = 1'h1;
        @(negedge clock);
        probeCaptureCmd = 1'h0;
        check(captureValid, 1'h1);
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (4) @(negedge clock);
        nrst = 1'h1;
        check(outValid, 1'h0);
        frame();
        take(2'h0, 1'h1, 1'h0, 24'h12_3456);
        repeat (4) @(negedge clock);
        check(sink.got.size(), 32'h0000_0000);
        capture(24'h00_0AAA);
        cfg(1'h1, 1'h0, 1'h1, 1'h0);
        frame();
        take(2'h0, 1'h1, 1'h0, 24'h00_0AAA);
        take(2'h1, 1'h1, 1'h1, 24'h00_0AAA);
        check(captureValid, 1'h0);
        counterZero = 24'h00_0BBB;
        probeTriggerPin = 1'h1;
        repeat (5) @(negedge clock);
        check(captureValid, 1'h1);
        frame();
        take(2'h0, 1'h1, 1'h0, 24'h00_0BBB);
        take(2'h1, 1'h1, 1'h0, 24'h00_0BBB);
        capture(24'h00_00FF);
        for (i = 0; i < 2; i++) begin
            cfg(1'h0, 1'h1, 1'h0, i[0]);
            frame();
            take(2'h0, 1'h1, 1'h0, 24'h00_00FF);
            take(2'h2, 1'h1, 1'h0, gray(i ? 24'h00_0BBB : 24'h00_00FF));
        end
        @(negedge clock);
        statusRead = 1'h1;
        @(negedge clock);
        statusRead = 1'h0;
        check(captureValid, 1'h0);
        frame();
        take(2'h0, 1'h1, 1'h0, 24'h00_00FF);
        take(2'h2, 1'h1, 1'h1, gray(24'h00_0BBB));
        abErrN = 1'h0;
        cfg(1'h1, 1'h0, 1'h0, 1'h0);
        frame();
        take(2'h0, 1'h1, 1'h0, 24'h00_00FF);
        take(2'h1, 1'h0, 1'h1, 24'h00_5A5A);
        cfg(1'h0, 1'h0, 1'h0, 1'h0);
        stall = 1'h1;
        for (i = 0; i < 34; i++) begin
            counterZero = i[23:0];
            frame();
        end
        check(frameBusy, 1'h1);
        stall = 1'h0;
        slow = 1'h1;
        for (i = 0; i < 34; i++)
            take(2'h0, 1'h1, 1'h0, i[23:0]);
        repeat (3) @(negedge clock);
        check(outValid, 1'h0);
        end_sim();
    end
endmodule // test_probe_capture_serial_readout
`default_nettype wire
